// file: aowpc_top.sv
// always-on wake-up and power control: wake timer, pin wake sources, sleep sequencing and power registers
//
// Notes on behaviour
// - 36-bit wake time held as low 32-bit word and high 4-bit word.
// - ten select bits pick one of two pins; matching bit picks edge.
// - bits 12..10 pick edge of fourth, third, second wake pins; 1 falling.
// - bits 28..26 enable wake from fourth, third, second wake pins.
// - bits 25..16 enable wake from each selected multiplexed pin.
// - read-only bits 13..10 flag which external wake pin woke the chip.
// - read-only bits 9..0 flag which multiplexed pin woke the chip.
// - control bit 6 enables primary wake pin wake-up; resets to 0.
// - control bit 2 sets primary pin edge, 0 rising, 1 falling.
// - control bit 1 lets primary pin events raise interrupt in normal mode.
// - control bits 5 and 4 enable brownout and blackout interrupts.
// - writing 1 to control bit 0 enters power-down; 0 does nothing.
// - clock source field 3:2 selects oscillator, crystal or test; reset 0.
// - bit 1 powers crystal, bit 0 powers oscillator; both reset to 1.
// - bits 22:16 enable retention mode per memory bank; reset 0.
// - bits 14:8 put each memory bank to sleep, losing contents.
// - bits 27..25 enable pad retention for flash io, port c, port a.
// - bit 2 low isolates shared port a pins 0..3; resets to 1.
// - bit 0 low isolates retention memory; resets to 0.
// - bits 7:4 hold software power-down information; reset 0.
// - auto power-on bit sleeps, wakes automatically, and resets all registers except the wake time, the counter and the pin wake status.
// - writing 1 to converter bit 0 switches the converter off.
// - wake source flags counter-match wake; writing 1 clears it.
module aowpc_top
  import aowpc_pkg::*;
(
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  // register port
  input  wire logic [31:0]         addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  // wake pins, asynchronous
  input  wire logic                primary_wake_pin_i,
  input  wire logic                second_wake_pin_i,
  input  wire logic                third_wake_pin_i,
  input  wire logic                fourth_wake_pin_i,
  input  wire logic [MUX_N-1:0]    wake_cand0_i,
  input  wire logic [MUX_N-1:0]    wake_cand1_i,
  // supply monitor events, asynchronous
  input  wire logic                brownout_i,
  input  wire logic                blackout_i,
  // sleep and interrupt requests
  output logic                     sleep_o,
  output logic                     wake_pin_irq_o,
  output logic                     brownout_irq_o,
  output logic                     blackout_irq_o,
  output logic                     watchdog_count_en_o,
  // slow clock control
  output logic      [1:0]          clk_sel_o,
  output logic                     crystal_power_enable_o,
  output logic                     osc_power_enable_o,
  output logic                     external_resistor_enable_o,
  // retention and power control
  output logic      [BANK_N-1:0]   bank_retention_enable_o,
  output logic      [BANK_N-1:0]   bank_sleep_enable_o,
  output logic      [2:0]          pad_retention_o,
  output logic                     shared_io_access_o,
  output logic                     retention_isolation_release_o,
  output logic                     dcdc_off_o
);

  localparam aowpc_state_t STATE_RST = '{regs: REGS_RST, mode: MODE_RUN, default: '0};

  aowpc_state_t        st_reg;
  aowpc_state_t        st_next;
  aowpc_pins_t         pins_in;
  aowpc_pins_t         rise;
  aowpc_pins_t         fall;
  logic [MUX_N-1:0]    mux_hit;
  logic [3:0]          ext_hit;
  logic                cmp_hit;
  logic                wake;

  // picks the qualified edge of one pin
  function automatic logic edge_hit(input logic r, input logic f, input logic falling);
    return falling ? f : r;
  endfunction

  // read view of the register map, unmapped addresses read zero
  function automatic logic [31:0] rd_word(input aowpc_regs_t r, input logic [CNT_W-1:0] cnt,
                                          input logic [31:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      OFS_WAKE_TIME_LOW:  w = r.wake_time[31:0];
      OFS_WAKE_TIME_HIGH: w[3:0] = r.wake_time[35:32];
      OFS_PIN_WAKE_SELECT_EDGE: begin
        w[CFG_SEL_LSB +: MUX_N]         = r.mux_sel;
        w[CFG_EXT_EDGE_LSB +: EXT_HI_N] = r.ext_edge;
        w[CFG_EDGE_LSB +: MUX_N]        = r.mux_edge;
      end
      OFS_PIN_WAKE_ENABLE_STATUS: begin
        w[CTL_EXT_EN_LSB +: EXT_HI_N]   = r.ext_en;
        w[CTL_MUX_EN_LSB +: MUX_N]      = r.mux_en;
        w[CTL_EXT_STAT_LSB +: 4]        = r.ext_stat;
        w[CTL_MUX_STAT_LSB +: MUX_N]    = r.mux_stat;
      end
      OFS_ALWAYS_ON_CONTROL: begin
        w[AO_PIN_EN_BIT]    = r.pin_en;
        w[AO_BROWN_IRQ_BIT] = r.brown_irq_en;
        w[AO_BLACK_IRQ_BIT] = r.black_irq_en;
        w[AO_WDOG_BIT]      = r.wdog_en;
        w[AO_POL_BIT]       = r.pin_falling;
        w[AO_PIN_IRQ_BIT]   = r.pin_irq_en;
        w[AO_PD_BIT]        = r.pd_req;
      end
      OFS_SLOW_CLOCK_CONTROL: begin
        w[XT_MISC_LSB +: 6]    = r.xt_misc;
        w[XT_EXT_RES_BIT]      = r.ext_res;
        w[XT_CLK_SEL_LSB +: 2] = r.clk_sel;
        w[XT_XTAL_BIT]         = r.xtal_pwr;
        w[XT_OSC_BIT]          = r.osc_pwr;
      end
      OFS_RETENTION_POWER_CONTROL: begin
        w[RET_PAD_LSB +: 3]          = r.pad_ret;
        w[RET_BANK_RET_LSB +: BANK_N] = r.bank_ret;
        w[RET_BANK_SLP_LSB +: BANK_N] = r.bank_slp;
        w[RET_INFO_LSB +: 4]         = r.pd_info;
        w[RET_SHARED_BIT]            = r.shared_io;
        w[RET_FLAG_BIT]              = r.info_flag;
        w[RET_ISO_BIT]               = r.iso_release;
      end
      OFS_CONVERTER_POWER_CONTROL: begin
        w[DC_AUTO_BIT] = r.auto_req;
        w[DC_OFF_BIT]  = r.dcdc_off;
      end
      OFS_WAKE_SOURCE: w[1:0] = r.src;
      OFS_COUNT_LOW:   w = cnt[31:0];
      OFS_COUNT_HIGH:  w[3:0] = cnt[35:32];
      default:         w = '0;
    endcase
    return w;
  endfunction

  // gather asynchronous inputs into one group for the synchroniser
  always_comb begin
    pins_in.brownout = brownout_i;
    pins_in.blackout = blackout_i;
    pins_in.cand1    = wake_cand1_i;
    pins_in.cand0    = wake_cand0_i;
    pins_in.ext      = {fourth_wake_pin_i, third_wake_pin_i, second_wake_pin_i, primary_wake_pin_i};
  end

  // next-state logic: synchroniser, counter, edges, register writes, sleep sequencing
  always_comb begin
    st_next = st_reg;
    // sync1 feeds sync2 only; edges are taken between sync2 and prev
    st_next.sync1 = pins_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    rise = st_reg.sync2 & ~st_reg.prev;
    fall = ~st_reg.sync2 & st_reg.prev;
    st_next.count = st_reg.count + 36'h1;
    cmp_hit = (st_reg.count == st_reg.regs.wake_time);
    // select one of two candidates before qualifying the edge
    for (int i = 0; i < MUX_N; i++) begin
      mux_hit[i] = st_reg.regs.mux_en[i] & edge_hit(st_reg.regs.mux_sel[i] ? rise.cand1[i] : rise.cand0[i],
                                                    st_reg.regs.mux_sel[i] ? fall.cand1[i] : fall.cand0[i],
                                                    st_reg.regs.mux_edge[i]);
    end
    ext_hit[0] = st_reg.regs.pin_en & edge_hit(rise.ext[0], fall.ext[0], st_reg.regs.pin_falling);
    for (int i = 0; i < EXT_HI_N; i++) begin
      ext_hit[i+1] = st_reg.regs.ext_en[i] & edge_hit(rise.ext[i+1], fall.ext[i+1], st_reg.regs.ext_edge[i]);
    end
    wake = cmp_hit | (|mux_hit) | (|ext_hit);
    // interrupt requests are one-cycle pulses; pin one only while running
    st_next.irq_pin   = (st_reg.mode == MODE_RUN) & st_reg.regs.pin_irq_en &
                        edge_hit(rise.ext[0], fall.ext[0], st_reg.regs.pin_falling);
    st_next.irq_brown = st_reg.regs.brown_irq_en & rise.brownout;
    st_next.irq_black = st_reg.regs.black_irq_en & rise.blackout;
    // read data stands only in the cycle after the strobe
    st_next.rdata = rd_i ? rd_word(st_reg.regs, st_reg.count, addr_i) : 32'h0;
    // register writes
    if (wr_i) begin
      unique case (addr_i)
        OFS_WAKE_TIME_LOW:  st_next.regs.wake_time[31:0]  = wdata_i;
        OFS_WAKE_TIME_HIGH: st_next.regs.wake_time[35:32] = wdata_i[3:0];
        OFS_PIN_WAKE_SELECT_EDGE: begin
          st_next.regs.mux_sel  = wdata_i[CFG_SEL_LSB +: MUX_N];
          st_next.regs.ext_edge = wdata_i[CFG_EXT_EDGE_LSB +: EXT_HI_N];
          st_next.regs.mux_edge = wdata_i[CFG_EDGE_LSB +: MUX_N];
        end
        OFS_PIN_WAKE_ENABLE_STATUS: begin
          // status fields are read-only
          st_next.regs.ext_en = wdata_i[CTL_EXT_EN_LSB +: EXT_HI_N];
          st_next.regs.mux_en = wdata_i[CTL_MUX_EN_LSB +: MUX_N];
        end
        OFS_ALWAYS_ON_CONTROL: begin
          st_next.regs.pin_en       = wdata_i[AO_PIN_EN_BIT];
          st_next.regs.brown_irq_en = wdata_i[AO_BROWN_IRQ_BIT];
          st_next.regs.black_irq_en = wdata_i[AO_BLACK_IRQ_BIT];
          st_next.regs.wdog_en      = wdata_i[AO_WDOG_BIT];
          st_next.regs.pin_falling  = wdata_i[AO_POL_BIT];
          st_next.regs.pin_irq_en   = wdata_i[AO_PIN_IRQ_BIT];
          st_next.regs.pd_req       = st_reg.regs.pd_req | wdata_i[AO_PD_BIT];
        end
        OFS_SLOW_CLOCK_CONTROL: begin
          st_next.regs.xt_misc  = wdata_i[XT_MISC_LSB +: 6];
          st_next.regs.ext_res  = wdata_i[XT_EXT_RES_BIT];
          st_next.regs.clk_sel  = wdata_i[XT_CLK_SEL_LSB +: 2];
          st_next.regs.xtal_pwr = wdata_i[XT_XTAL_BIT];
          st_next.regs.osc_pwr  = wdata_i[XT_OSC_BIT];
        end
        OFS_RETENTION_POWER_CONTROL: begin
          st_next.regs.pad_ret     = wdata_i[RET_PAD_LSB +: 3];
          st_next.regs.bank_ret    = wdata_i[RET_BANK_RET_LSB +: BANK_N];
          st_next.regs.bank_slp    = wdata_i[RET_BANK_SLP_LSB +: BANK_N];
          st_next.regs.pd_info     = wdata_i[RET_INFO_LSB +: 4];
          st_next.regs.shared_io   = wdata_i[RET_SHARED_BIT];
          st_next.regs.info_flag   = wdata_i[RET_FLAG_BIT];
          st_next.regs.iso_release = wdata_i[RET_ISO_BIT];
        end
        OFS_CONVERTER_POWER_CONTROL: begin
          // both bits act on a written 1 only
          st_next.regs.auto_req = st_reg.regs.auto_req | wdata_i[DC_AUTO_BIT];
          st_next.regs.dcdc_off = st_reg.regs.dcdc_off | wdata_i[DC_OFF_BIT];
        end
        OFS_WAKE_SOURCE: st_next.regs.src = st_reg.regs.src & ~wdata_i[1:0];
        default: ;
      endcase
    end
    // sleep sequencing; sets below come after the clears above so a set wins
    unique case (st_reg.mode)
      MODE_RUN: begin
        if (st_reg.regs.pd_req | st_reg.regs.auto_req) begin
          st_next.mode = MODE_SLEEP;
          // a new wake cycle forgets the previous pin source
          st_next.regs.ext_stat = '0;
          st_next.regs.mux_stat = '0;
        end
      end
      MODE_SLEEP: begin
        if (wake) begin
          st_next.mode = MODE_RUN;
          if (st_reg.regs.auto_req) begin
            // counter, wake time and the cause of this wake survive the reset
            st_next.regs = REGS_RST;
            st_next.regs.wake_time = st_reg.regs.wake_time;
          end
          st_next.regs.pd_req   = 1'b0;
          st_next.regs.auto_req = 1'b0;
          st_next.regs.ext_stat = st_reg.regs.ext_stat | ext_hit;
          st_next.regs.mux_stat = st_reg.regs.mux_stat | mux_hit;
          st_next.regs.src[SRC_EXT_BIT] = st_next.regs.src[SRC_EXT_BIT] | (|ext_hit);
          st_next.regs.src[SRC_CMP_BIT] = st_next.regs.src[SRC_CMP_BIT] | cmp_hit;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flip-flops
  assign rdata_o                       = st_reg.rdata;
  assign sleep_o                       = (st_reg.mode == MODE_SLEEP);
  assign wake_pin_irq_o                = st_reg.irq_pin;
  assign brownout_irq_o                = st_reg.irq_brown;
  assign blackout_irq_o                = st_reg.irq_black;
  assign watchdog_count_en_o           = st_reg.regs.wdog_en;
  assign clk_sel_o                     = st_reg.regs.clk_sel;
  assign crystal_power_enable_o        = st_reg.regs.xtal_pwr;
  assign osc_power_enable_o            = st_reg.regs.osc_pwr;
  assign external_resistor_enable_o    = st_reg.regs.ext_res;
  assign bank_retention_enable_o       = st_reg.regs.bank_ret;
  assign bank_sleep_enable_o           = st_reg.regs.bank_slp;
  assign pad_retention_o               = st_reg.regs.pad_ret;
  assign shared_io_access_o            = st_reg.regs.shared_io;
  assign retention_isolation_release_o = st_reg.regs.iso_release;
  assign dcdc_off_o                    = st_reg.regs.dcdc_off;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  property p_wake_time_read;
    rd_i && addr_i == OFS_WAKE_TIME_LOW |=> rdata_o == $past(st_reg.regs.wake_time[31:0]);
  endproperty
  a_wake_time_read: assert property (p_wake_time_read) else $error("wake time low read mismatch");

  property p_mux_latch;
    $rose(st_reg.regs.mux_stat[0]) |-> $past(st_reg.regs.mux_en[0]) && $past(st_reg.mode) == MODE_SLEEP;
  endproperty
  a_mux_latch: assert property (p_mux_latch) else $error("mux status set without enable in sleep");

  property p_pin_irq;
    wake_pin_irq_o |-> $past(st_reg.regs.pin_irq_en) && $past(st_reg.mode) == MODE_RUN;
  endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("pin interrupt without enable");

  property p_brown_irq;
    brownout_irq_o |-> $past(st_reg.regs.brown_irq_en) && $past(st_reg.sync2.brownout);
  endproperty
  a_brown_irq: assert property (p_brown_irq) else $error("brownout interrupt without enable");

  property p_power_down;
    wr_i && addr_i == OFS_ALWAYS_ON_CONTROL && wdata_i[AO_PD_BIT] && !sleep_o && !st_reg.regs.pd_req
      && !st_reg.regs.auto_req |-> ##2 sleep_o;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down write did not enter sleep");

  property p_dcdc_zero;
    wr_i && addr_i == OFS_CONVERTER_POWER_CONTROL && !wdata_i[DC_OFF_BIT] && dcdc_off_o && !sleep_o
      |=> dcdc_off_o;
  endproperty
  a_dcdc_zero: assert property (p_dcdc_zero) else $error("writing zero turned converter back on");

  property p_cmp_source;
    st_reg.mode == MODE_SLEEP && cmp_hit |=> st_reg.regs.src[SRC_CMP_BIT] && !sleep_o;
  endproperty
  a_cmp_source: assert property (p_cmp_source) else $error("counter match wake not flagged");

  property p_auto_reset;
    st_reg.mode == MODE_SLEEP && st_reg.regs.auto_req && wake |=> clk_sel_o == CLK_SEL_RST
      && shared_io_access_o && !st_reg.regs.auto_req && !sleep_o;
  endproperty
  a_auto_reset: assert property (p_auto_reset) else $error("auto wake did not reset registers");

  property p_status_hold;
    st_reg.mode == MODE_RUN && !st_reg.regs.pd_req && !st_reg.regs.auto_req
      |=> st_reg.regs.mux_stat == $past(st_reg.regs.mux_stat) && st_reg.regs.ext_stat == $past(st_reg.regs.ext_stat);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("wake status changed while running");

endmodule

// file: aowpc_pkg.sv
// package: register map, field layout, reset values and state types of the always-on wake and power control
package aowpc_pkg;

  // sizes
  localparam int unsigned MUX_N    = 10;
  localparam int unsigned EXT_HI_N = 3;
  localparam int unsigned BANK_N   = 7;
  localparam int unsigned CNT_W    = 36;

  // register byte addresses
  localparam logic [31:0] OFS_WAKE_TIME_LOW           = 32'h5009_1000;
  localparam logic [31:0] OFS_WAKE_TIME_HIGH          = 32'h5009_1004;
  localparam logic [31:0] OFS_PIN_WAKE_SELECT_EDGE    = 32'h5009_1008;
  localparam logic [31:0] OFS_PIN_WAKE_ENABLE_STATUS  = 32'h5009_100c;
  localparam logic [31:0] OFS_ALWAYS_ON_CONTROL       = 32'h5009_1010;
  localparam logic [31:0] OFS_SLOW_CLOCK_CONTROL      = 32'h5009_1014;
  localparam logic [31:0] OFS_RETENTION_POWER_CONTROL = 32'h5009_1018;
  localparam logic [31:0] OFS_CONVERTER_POWER_CONTROL = 32'h5009_101c;
  localparam logic [31:0] OFS_WAKE_SOURCE             = 32'h5009_1028;
  localparam logic [31:0] OFS_COUNT_LOW               = 32'h5009_1038;
  localparam logic [31:0] OFS_COUNT_HIGH              = 32'h5009_103c;

  // field positions
  localparam int unsigned CFG_SEL_LSB      = 16;
  localparam int unsigned CFG_EXT_EDGE_LSB = 10;
  localparam int unsigned CFG_EDGE_LSB     = 0;
  localparam int unsigned CTL_EXT_EN_LSB   = 26;
  localparam int unsigned CTL_MUX_EN_LSB   = 16;
  localparam int unsigned CTL_EXT_STAT_LSB = 10;
  localparam int unsigned CTL_MUX_STAT_LSB = 0;
  localparam int unsigned AO_PIN_EN_BIT    = 6;
  localparam int unsigned AO_BROWN_IRQ_BIT = 5;
  localparam int unsigned AO_BLACK_IRQ_BIT = 4;
  localparam int unsigned AO_WDOG_BIT      = 3;
  localparam int unsigned AO_POL_BIT       = 2;
  localparam int unsigned AO_PIN_IRQ_BIT   = 1;
  localparam int unsigned AO_PD_BIT        = 0;
  localparam int unsigned XT_MISC_LSB      = 5;
  localparam int unsigned XT_EXT_RES_BIT   = 4;
  localparam int unsigned XT_CLK_SEL_LSB   = 2;
  localparam int unsigned XT_XTAL_BIT      = 1;
  localparam int unsigned XT_OSC_BIT       = 0;
  localparam int unsigned RET_PAD_LSB      = 25;
  localparam int unsigned RET_BANK_RET_LSB = 16;
  localparam int unsigned RET_BANK_SLP_LSB = 8;
  localparam int unsigned RET_INFO_LSB     = 4;
  localparam int unsigned RET_SHARED_BIT   = 2;
  localparam int unsigned RET_FLAG_BIT     = 1;
  localparam int unsigned RET_ISO_BIT      = 0;
  localparam int unsigned DC_AUTO_BIT      = 1;
  localparam int unsigned DC_OFF_BIT       = 0;
  localparam int unsigned SRC_EXT_BIT      = 0;
  localparam int unsigned SRC_CMP_BIT      = 1;

  // reset values of the slow clock control fields
  localparam logic [5:0] XT_MISC_RST = 6'h04;
  localparam logic [1:0] CLK_SEL_RST = 2'h0;

  typedef enum logic {MODE_RUN, MODE_SLEEP} aowpc_mode_t;

  // synchronised pin group, ext[0] is the primary wake pin
  typedef struct packed {
    logic              brownout;
    logic              blackout;
    logic [MUX_N-1:0]  cand1;
    logic [MUX_N-1:0]  cand0;
    logic [3:0]        ext;
  } aowpc_pins_t;

  typedef struct packed {
    logic [CNT_W-1:0]    wake_time;
    logic [MUX_N-1:0]    mux_sel;
    logic [MUX_N-1:0]    mux_edge;
    logic [EXT_HI_N-1:0] ext_edge;
    logic [EXT_HI_N-1:0] ext_en;
    logic [MUX_N-1:0]    mux_en;
    logic [3:0]          ext_stat;
    logic [MUX_N-1:0]    mux_stat;
    logic                pin_en;
    logic                brown_irq_en;
    logic                black_irq_en;
    logic                wdog_en;
    logic                pin_falling;
    logic                pin_irq_en;
    logic                pd_req;
    logic [5:0]          xt_misc;
    logic                ext_res;
    logic [1:0]          clk_sel;
    logic                xtal_pwr;
    logic                osc_pwr;
    logic [2:0]          pad_ret;
    logic [BANK_N-1:0]   bank_ret;
    logic [BANK_N-1:0]   bank_slp;
    logic [3:0]          pd_info;
    logic                shared_io;
    logic                info_flag;
    logic                iso_release;
    logic                auto_req;
    logic                dcdc_off;
    logic [1:0]          src;
  } aowpc_regs_t;

  localparam aowpc_regs_t REGS_RST = '{xt_misc: XT_MISC_RST, clk_sel: CLK_SEL_RST, xtal_pwr: 1'b1,
                                        osc_pwr: 1'b1, shared_io: 1'b1, default: '0};

  typedef struct packed {
    aowpc_regs_t      regs;
    aowpc_mode_t      mode;
    logic [CNT_W-1:0] count;
    aowpc_pins_t      sync1;
    aowpc_pins_t      sync2;
    aowpc_pins_t      prev;
    logic [31:0]      rdata;
    logic             irq_pin;
    logic             irq_brown;
    logic             irq_black;
  } aowpc_state_t;

endpackage

// file: aowpc_pin_model.sv
// pin-side model: wake pins, candidate pins and supply events
module aowpc_pin_model
  import aowpc_pkg::*;
(
  // clock and requested levels
  input  wire logic             clk_sys_i,
  input  wire logic [25:0]      want_i,
  // levels seen by the block
  output logic      [3:0]       ext_o,
  output logic      [MUX_N-1:0] cand0_o,
  output logic      [MUX_N-1:0] cand1_o,
  output logic      [1:0]       supply_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pads move off the edge, they are not tied to our clock
  initial {supply_o, cand1_o, cand0_o, ext_o} = '0;
  always @(posedge clk_sys_i) begin
    {supply_o, cand1_o, cand0_o, ext_o} <= #7 want_i;
  end
endmodule

// file: aowpc_top_bench.sv
// self-checking bench for the always-on wake and power control
module aowpc_top_bench
  import aowpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk, rstn, wr, rd, slp, irq_p, irq_br, irq_bl, xt, osc, sh, iso, dc;
  logic             wd, xr;
  logic [1:0]       csel, sup;
  logic [2:0]       pad;
  logic [BANK_N-1:0] bret, bslp;
  logic [3:0]       ext;
  logic [MUX_N-1:0] c0, c1;
  logic [25:0]      want;
  logic [31:0]      addr, wdata, rdata, r;
  int               fail_count, n_compared, n_irq, n_br, n_bl, cyc;
  // far side and block
  aowpc_pin_model pins (.clk_sys_i(clk), .want_i(want), .ext_o(ext), .cand0_o(c0), .cand1_o(c1), .supply_o(sup));
  aowpc_top uut (.clk_sys_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .primary_wake_pin_i(ext[0]), .second_wake_pin_i(ext[1]), .third_wake_pin_i(ext[2]),
    .fourth_wake_pin_i(ext[3]), .wake_cand0_i(c0), .wake_cand1_i(c1), .brownout_i(sup[1]), .blackout_i(sup[0]),
    .sleep_o(slp), .wake_pin_irq_o(irq_p), .brownout_irq_o(irq_br), .blackout_irq_o(irq_bl),
    .watchdog_count_en_o(wd), .clk_sel_o(csel), .crystal_power_enable_o(xt), .osc_power_enable_o(osc),
    .external_resistor_enable_o(xr), .bank_retention_enable_o(bret), .bank_sleep_enable_o(bslp),
    .pad_retention_o(pad),
    .shared_io_access_o(sh), .retention_isolation_release_o(iso), .dcdc_off_o(dc));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // pulses are counted, since each stands one cycle only
  always @(posedge clk) begin
    if (irq_p === 1'b1) n_irq <= n_irq + 1;
    if (irq_br === 1'b1) n_br <= n_br + 1;
    if (irq_bl === 1'b1) n_bl <= n_bl + 1;
    // rough copy of the free-running count, only used to aim a wake time ahead
    cyc <= rstn ? cyc + 1 : 0;
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] e, logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr32(logic [31:0] a, logic [31:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(string what, logic [31:0] a, logic [31:0] e);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk(what, e, rdata);
  endtask
  // bounded wait for the sleep level
  task automatic wait_sleep(logic lvl);
    int i;
    for (i = 0; i < 200 && slp !== lvl; i++) @(posedge clk);
    chk("sleep", {31'h0, lvl}, {31'h0, slp});
    if (i == 200) wrap_up();
  endtask
  // main sequence
  initial begin
    {rstn, wr, rd, addr, wdata, want} = '0;
    {fail_count, n_compared, n_irq, n_br, n_bl} = '0;
    r = $urandom(32'hf74e0277);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("reset outputs", 32'h1c, {24'h0, slp, csel, xt, osc, sh, iso, dc});
    rd_chk("slow clock", OFS_SLOW_CLOCK_CONTROL, 32'h83);
    rd_chk("retention", OFS_RETENTION_POWER_CONTROL, 32'h4);
    rd_chk("control", OFS_ALWAYS_ON_CONTROL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      r = $urandom();
      wr32(OFS_WAKE_TIME_LOW, r);
      rd_chk("time low", OFS_WAKE_TIME_LOW, r);
      wr32(OFS_WAKE_TIME_HIGH, r);
      rd_chk("time high", OFS_WAKE_TIME_HIGH, r & 32'hf);
      wr32(OFS_PIN_WAKE_SELECT_EDGE, r);
      rd_chk("select edge", OFS_PIN_WAKE_SELECT_EDGE, r & 32'h03ff_1fff);
      wr32(OFS_RETENTION_POWER_CONTROL, r);
      rd_chk("retention", OFS_RETENTION_POWER_CONTROL, r & 32'h0e7f_7ff7);
      chk("retention pins", {15'h0, r[27:25], r[22:16], r[14:8]}, {15'h0, pad, bret, bslp});
      wr32(OFS_PIN_WAKE_ENABLE_STATUS, r);
      rd_chk("wake enable", OFS_PIN_WAKE_ENABLE_STATUS, r & 32'h1fff_0000);
    end
    rd_chk("unmapped", 32'h5009_1024, 32'h0);
    $display("registers done");
    // primary pin: rise, fall, rise, fall under changing enable and polarity
    for (int k = 0; k < 4; k++) begin
      wr32(OFS_ALWAYS_ON_CONTROL, k == 3 ? 32'h0 : (k == 0 ? 32'h2 : 32'h6));
      r = n_irq;
      want[0] <= ~want[0];
      repeat (8) @(posedge clk);
      chk("pin irq", k < 2 ? r + 1 : r, n_irq);
    end
    wr32(OFS_ALWAYS_ON_CONTROL, 32'h28);
    want[25:24] <= 2'b11;
    repeat (8) @(posedge clk);
    chk("supply irq", 32'h0001_0000, {n_br[15:0], n_bl[15:0]});
    chk("watchdog enable", 32'h1, {31'h0, wd});
    $display("interrupts done");
    // sleep, ignore a disabled pin, wake on the fourth pin
    wr32(OFS_PIN_WAKE_SELECT_EDGE, 32'h0);
    wr32(OFS_PIN_WAKE_ENABLE_STATUS, 32'h1000_0000);
    wr32(OFS_ALWAYS_ON_CONTROL, 32'h1);
    wait_sleep(1'b1);
    want[2] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("still asleep", 32'h1, {31'h0, slp});
    want[3] <= 1'b1;
    wait_sleep(1'b0);
    rd_chk("wake status", OFS_PIN_WAKE_ENABLE_STATUS, 32'h1000_2000);
    rd_chk("wake source", OFS_WAKE_SOURCE, 32'h1);
    wr32(OFS_WAKE_SOURCE, 32'h1);
    rd_chk("source clear", OFS_WAKE_SOURCE, 32'h0);
    $display("pin wake done");
    // converter off is sticky against a written zero
    wr32(OFS_CONVERTER_POWER_CONTROL, 32'h1);
    wr32(OFS_CONVERTER_POWER_CONTROL, 32'h0);
    #1 chk("converter off", 32'h1, {31'h0, dc});
    $display("converter done");
    // source 0 takes candidate 1 on a falling edge; candidate 0 must be ignored
    wr32(OFS_PIN_WAKE_SELECT_EDGE, 32'h0001_0001);
    want[14] <= 1'b1;
    want[4]  <= 1'b1;
    wr32(OFS_PIN_WAKE_ENABLE_STATUS, 32'h0001_0000);
    wr32(OFS_ALWAYS_ON_CONTROL, 32'h1);
    wait_sleep(1'b1);
    want[4] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("unselected pin", 32'h1, {31'h0, slp});
    want[14] <= 1'b0;
    wait_sleep(1'b0);
    rd_chk("mux status", OFS_PIN_WAKE_ENABLE_STATUS, 32'h0001_0001);
    rd_chk("mux source", OFS_WAKE_SOURCE, 32'h0);
    $display("mux wake done");
    // counter-match wake under auto power-on puts the configuration back to reset
    wr32(OFS_SLOW_CLOCK_CONTROL, 32'h14);
    #1 chk("slow clock pins", 32'h14, {27'h0, xr, csel, xt, osc});
    wr32(OFS_WAKE_TIME_HIGH, 32'h0);
    wr32(OFS_WAKE_TIME_LOW, cyc + 60);
    wr32(OFS_CONVERTER_POWER_CONTROL, 32'h2);
    wait_sleep(1'b1);
    wait_sleep(1'b0);
    #1 chk("auto reset outputs", 32'h1c, {24'h0, slp, csel, xt, osc, sh, iso, dc});
    rd_chk("counter source", OFS_WAKE_SOURCE, 32'h2);
    $display("auto wake done");
    wrap_up();
  end
endmodule
